// [core/aei_event_irq.sv]
// aei_event_irq: event enables, interrupt enables, sticky interrupt flags
// and sync status of a converter, reached over AXI4-Lite.
// assumes the converter core and event routing run on clk and give
// one-cycle pulses; the result word is held stable by the core.
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none

module aei_event_irq
(
  input  wire logic        clk,
  input  wire logic        rst,
  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // protection and converter core side
  input  wire logic        write_protect,
  input  wire logic        result_strobe,
  input  wire logic [15:0] result_data,
  input  wire logic        window_hit,
  input  wire logic        sync_begin,
  input  wire logic        sync_quiet,
  input  wire logic        sync_end,
  // event system side
  input  wire logic        start_event_in,
  input  wire logic        flush_event_in,
  output var  logic        result_event_out,
  output var  logic        window_event_out,
  output var  logic        conv_start,
  output var  logic        conv_flush,
  output var  logic        irq
);

  //////////////////////////////////////////////////////////////////////////////
  // state
  logic [7:0]  event_ctrl;
  logic [3:0]  irq_en;
  logic [3:0]  irq_flags;
  logic        sync_pending;
  logic        sync_is_quiet;
  logic        result_unread;
  logic [15:0] result_hold;
  logic        window_seen;
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;

  logic        wr_go;
  logic        rd_go;
  logic [7:0]  wr_idx;
  logic [7:0]  rd_idx;
  logic        wr_low;
  logic        wr_ok;
  logic        rd_result;
  logic [3:0]  flag_set;
  logic [3:0]  flag_clr;
  logic [3:0]  next_flags;
  logic [3:0]  next_en;
  logic        sync_fall;

  //////////////////////////////////////////////////////////////////////////////
  // write channel: address and data taken in either order
  assign wr_go  = aw_held && w_held && !s_axi_bvalid;
  assign wr_idx = {2'b00, aw_addr[7:2]};
  assign wr_low = w_strb[0];
  assign rd_go  = s_axi_arvalid && s_axi_arready;
  assign rd_idx = {2'b00, s_axi_araddr[7:2]};

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h00000000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      else if (wr_go)
        aw_held <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      else if (wr_go)
        w_held <= 1'b0;
      // ready drops the cycle after a beat so nothing is taken twice
      s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready) && !wr_go;
      s_axi_wready  <= !w_held && !(s_axi_wvalid && s_axi_wready) && !wr_go;
    end
  end

  // write decode: mapped index, protection on the protected registers
  always_comb
  begin
    wr_ok = 1'b0;
    case (wr_idx)
      aei_pkg::EVENT_CTRL_IDX,
      aei_pkg::IRQ_EN_CLR_IDX,
      aei_pkg::IRQ_EN_SET_IDX: wr_ok = !write_protect;
      aei_pkg::IRQ_FLAGS_IDX,
      aei_pkg::FLAG_CLR_IDX:   wr_ok = 1'b1;
      default:                 wr_ok = 1'b0;
    endcase
  end

  // write response one cycle after both halves are held
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= aei_pkg::RESP_OKAY;
    end
    else if (wr_go)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ok ? aei_pkg::RESP_OKAY : aei_pkg::RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // event control register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      event_ctrl <= aei_pkg::EVENT_CTRL_RST;
    else if (wr_go && wr_ok && wr_low && wr_idx == aei_pkg::EVENT_CTRL_IDX)
      event_ctrl <= w_data[7:0] & 8'h33; // unused bits stay zero
  end

  // interrupt enables: one-to-clear and one-to-set views of one register
  always_comb
  begin
    next_en = irq_en;
    if (wr_go && wr_ok && wr_low && wr_idx == aei_pkg::IRQ_EN_CLR_IDX)
      next_en = irq_en & ~w_data[3:0];
    if (wr_go && wr_ok && wr_low && wr_idx == aei_pkg::IRQ_EN_SET_IDX)
      next_en = irq_en | w_data[3:0];
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      irq_en <= aei_pkg::IRQ_EN_RST;
    else
      irq_en <= next_en;
  end

  //////////////////////////////////////////////////////////////////////////////
  // sync pending tracking; quiet syncs come from enable or soft reset
  assign sync_fall = sync_pending && sync_end && !sync_begin;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sync_pending  <= 1'b0;
      sync_is_quiet <= 1'b0;
    end
    else if (sync_begin)
    begin
      sync_pending  <= 1'b1;
      sync_is_quiet <= sync_quiet;
    end
    else if (sync_end)
      sync_pending  <= 1'b0;
  end

  // window hit is registered so its flag lands one cycle after the result flag
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      window_seen <= 1'b0;
    else
      window_seen <= window_hit;
  end

  //////////////////////////////////////////////////////////////////////////////
  // flags: set beats clear so no event is lost
  assign rd_result = rd_go && rd_idx == aei_pkg::RESULT_IDX;

  always_comb
  begin
    flag_set = 4'h0;
    flag_clr = 4'h0;
    flag_set[aei_pkg::RESULT_VALID_BIT] = result_strobe;
    flag_set[aei_pkg::OVERRUN_BIT]      = result_strobe && result_unread
                                          && !rd_result;
    flag_set[aei_pkg::WINDOW_MATCH_BIT] = window_seen;
    flag_set[aei_pkg::SYNC_DONE_BIT]    = sync_fall && !sync_is_quiet;
    if (wr_go && wr_ok && wr_low
        && (wr_idx == aei_pkg::IRQ_FLAGS_IDX || wr_idx == aei_pkg::FLAG_CLR_IDX))
      flag_clr = w_data[3:0];
    flag_clr[aei_pkg::RESULT_VALID_BIT] = flag_clr[aei_pkg::RESULT_VALID_BIT]
                                          || rd_result;
    flag_clr[aei_pkg::WINDOW_MATCH_BIT] = flag_clr[aei_pkg::WINDOW_MATCH_BIT]
                                          || rd_result;
    next_flags = (irq_flags & ~flag_clr) | flag_set;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      irq_flags <= aei_pkg::IRQ_FLAGS_RST;
    else
      irq_flags <= next_flags;
  end

  // held result and its unread marker
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      result_hold   <= aei_pkg::RESULT_RST;
      result_unread <= 1'b0;
    end
    else if (result_strobe)
    begin
      result_hold   <= result_data;
      result_unread <= 1'b1;
    end
    else if (rd_result)
      result_unread <= 1'b0;
  end

  // interrupt line follows the flags in the same cycle they update
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      irq <= 1'b0;
    else
      irq <= |(next_flags & next_en);
  end

  //////////////////////////////////////////////////////////////////////////////
  // event inputs and outputs, one-cycle pulses
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      conv_start       <= 1'b0;
      conv_flush       <= 1'b0;
      result_event_out <= 1'b0;
      window_event_out <= 1'b0;
    end
    else
    begin
      conv_flush       <= flush_event_in && event_ctrl[aei_pkg::FLUSH_IN_BIT];
      conv_start       <= (start_event_in && event_ctrl[aei_pkg::START_IN_BIT])
                          || (flush_event_in && event_ctrl[aei_pkg::FLUSH_IN_BIT]);
      result_event_out <= result_strobe && event_ctrl[aei_pkg::RESULT_OUT_BIT];
      window_event_out <= window_hit && event_ctrl[aei_pkg::WINDOW_OUT_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read channel: answer one cycle after the address is taken
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= aei_pkg::RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !rd_go;
      if (rd_go)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= aei_pkg::RESP_OKAY;
        s_axi_rdata  <= 32'h00000000;
        case (rd_idx)
          aei_pkg::EVENT_CTRL_IDX: s_axi_rdata[7:0] <= event_ctrl;
          aei_pkg::IRQ_EN_CLR_IDX,
          aei_pkg::IRQ_EN_SET_IDX: s_axi_rdata[3:0] <= irq_en;
          aei_pkg::IRQ_FLAGS_IDX:  s_axi_rdata[3:0] <= irq_flags;
          aei_pkg::SYNC_STAT_IDX:
            s_axi_rdata[aei_pkg::SYNC_PENDING_BIT] <= sync_pending;
          aei_pkg::RESULT_IDX:     s_axi_rdata[15:0] <= result_hold;
          aei_pkg::FLAG_CLR_IDX:   s_axi_rdata <= 32'h00000000;
          default:                 s_axi_rresp <= aei_pkg::RESP_SLVERR;
        endcase
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// [core/aei_pkg.sv]
// aei_pkg: register map, field layout and reset values of the converter
// event and interrupt control block.
// assumes a 32-bit AXI4-Lite register bus with one aligned word per register.
package aei_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // register indices; the byte address is four times the index
  localparam logic [7:0] EVENT_CTRL_IDX = 8'h14;
  localparam logic [7:0] IRQ_EN_CLR_IDX = 8'h16;
  localparam logic [7:0] IRQ_EN_SET_IDX = 8'h17;
  localparam logic [7:0] IRQ_FLAGS_IDX  = 8'h18;
  localparam logic [7:0] SYNC_STAT_IDX  = 8'h19;
  localparam logic [7:0] RESULT_IDX     = 8'h1a;
  localparam logic [7:0] FLAG_CLR_IDX   = 8'h30;

  localparam int         ADDR_W         = 8;

  //////////////////////////////////////////////////////////////////////////////
  // event control field positions
  localparam int START_IN_BIT   = 0;
  localparam int FLUSH_IN_BIT   = 1;
  localparam int RESULT_OUT_BIT = 4;
  localparam int WINDOW_OUT_BIT = 5;

  // shared layout of enable-clear, enable-set and flag registers
  localparam int RESULT_VALID_BIT = 0;
  localparam int OVERRUN_BIT      = 1;
  localparam int WINDOW_MATCH_BIT = 2;
  localparam int SYNC_DONE_BIT    = 3;
  localparam int IRQ_SRC_N        = 4;

  // status layout
  localparam int SYNC_PENDING_BIT = 7;

  //////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [7:0]  EVENT_CTRL_RST = 8'h00;
  localparam logic [3:0]  IRQ_EN_RST     = 4'h0;
  localparam logic [3:0]  IRQ_FLAGS_RST  = 4'h0;
  localparam logic [15:0] RESULT_RST     = 16'h0000;

  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// [dv/aei_core_model.sv]
// aei_core_model: converter core stand-in; a result follows each start.
// assumes conv_start pulses from the block; result word held until next.
`timescale 1ns/100ps
`default_nettype none
module aei_core_model
#(
  parameter int LAT = 3
)
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        conv_start,
  input  wire logic [15:0] seed_data,
  output var  logic        result_strobe,
  output var  logic [15:0] result_data,
  output var  logic        window_hit
);
  logic [3:0] cnt;
  ////////////////////////////////////////
  // a restart reloads the count, so a flush drops the old conversion
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt <= 4'h0;
      result_strobe <= 1'h0;
      result_data <= 16'h0000;
      window_hit <= 1'h0;
    end
    else
    begin
      result_strobe <= 1'h0;
      window_hit <= 1'h0;
      if (conv_start)
        cnt <= 4'(LAT);
      else if (cnt == 4'h1)
      begin
        cnt <= 4'h0;
        result_strobe <= 1'h1;
        result_data <= seed_data;
        window_hit <= seed_data[15]; // top bit stands for a window match
      end
      else if (cnt != 4'h0)
        cnt <= cnt - 4'h1;
    end
  end
endmodule
`default_nettype wire

// [dv/aei_event_irq_chk.sv]
// aei_event_irq_chk: port-level assertions for aei_event_irq.
// assumes one clock clk and asynchronous active-high rst.
`timescale 1ns/100ps
`default_nettype none
module aei_event_irq_chk
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        result_strobe,
  input wire logic        window_hit,
  input wire logic        start_event_in,
  input wire logic        flush_event_in,
  input wire logic        result_event_out,
  input wire logic        window_event_out,
  input wire logic        conv_start,
  input wire logic        conv_flush
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  // write: both beats taken, one held cycle, then response
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence resp_late;
    !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence
  AST_WR_LAT: assert property (wr_taken |=> resp_late)
    else $error("write response out of step");
  AST_RD_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
    else $error("read data moved");
  // event outputs only ever follow their cause by one cycle
  AST_RES_EVT: assert property (result_event_out |-> $past(result_strobe))
    else $error("stray result event");
  AST_WIN_EVT: assert property (window_event_out |-> $past(window_hit))
    else $error("stray window event");
  AST_FLUSH: assert property (conv_flush |-> conv_start && $past(flush_event_in))
    else $error("flush without restart");
  AST_START: assert property (conv_start |-> $past(start_event_in) || $past(flush_event_in))
    else $error("stray start");
endmodule
bind aei_event_irq aei_event_irq_chk chk (.*);
`default_nettype wire

// [dv/tb_aei_event_irq.sv]
// tb_aei_event_irq: self-checking bench of the event and interrupt block.
// assumes the core model answers each start after LAT cycles.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin err_count++; \
  $display("CHECK FAILED at %0t: value mismatch", $time); end end
module tb_aei_event_irq;
  localparam int         LAT = 3;
  localparam logic [1:0] OK  = aei_pkg::RESP_OKAY;
  localparam logic [7:0] RA [6] = '{8'h50, 8'h58, 8'h5c, 8'h60, 8'h64, 8'h68};
  logic        clk = 1'h0;
  logic        rst = 1'h1;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, write_protect = 1'h0;
  logic        sync_begin = 1'h0, sync_quiet = 1'h0, sync_end = 1'h0;
  logic        start_event_in = 1'h0, flush_event_in = 1'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        result_strobe, window_hit, result_event_out, window_event_out;
  logic        conv_start, conv_flush, irq;
  logic [15:0] result_data, seed_data = 16'h0;
  logic [31:0] rs = 32'h00012cfa;
  logic [34:0] exq [$];
  int          err_count, check_count, n_start, n_flush, n_res, n_win;

  aei_event_irq dut (.*);
  aei_core_model #(.LAT(LAT)) core (.*);

  always #12.5 clk = ~clk;
  ////////////////////////////////////////
  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  // bus master: beats released when taken, ready held until the answer;
  // a nonzero stall raises ready late so the slave must hold its answer
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = OK,
                    input int stall = 0);
    exq.push_back({1'h1, r, 32'h0});
    @(posedge clk);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {2'h3, stall == 0};
    do
    begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    if (stall != 0)
    begin
      repeat (stall) @(posedge clk);
      s_axi_bready <= 1'h1;
      @(posedge clk);
    end
    s_axi_bready <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = OK,
                    input int stall = 0);
    exq.push_back({1'h0, r, d});
    @(posedge clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= {1'h1, stall == 0};
    do
    begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    if (stall != 0)
    begin
      repeat (stall) @(posedge clk);
      s_axi_rready <= 1'h1;
      @(posedge clk);
    end
    s_axi_rready <= 1'h0;
  endtask
  // one-cycle pulse on the core and event inputs, then let it settle
  task automatic evp(input logic [3:0] m);
    @(posedge clk);
    {sync_end, sync_begin, flush_event_in, start_event_in} <= m;
    @(posedge clk);
    {sync_end, sync_begin, flush_event_in, start_event_in} <= 4'h0;
    repeat (LAT + 4) @(posedge clk);
  endtask
  task automatic end_of_test;
    $display("checks %0d, errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  ////////////////////////////////////////
  // monitor: oldest note against each answer; event pulses counted
  always @(posedge clk)
  begin
    n_start += int'(conv_start);
    n_flush += int'(conv_flush);
    n_res += int'(result_event_out);
    n_win += int'(window_event_out);
    if (s_axi_rvalid && s_axi_rready) `CHK({1'h0, s_axi_rresp, s_axi_rdata}, exq.pop_front())
    if (s_axi_bvalid && s_axi_bready) `CHK({1'h1, s_axi_bresp, 32'h0}, exq.pop_front())
  end
  initial
  begin
    repeat (5000) @(posedge clk);
    err_count++;
    end_of_test;
  end
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'h0;
    repeat (2) @(posedge clk);
    foreach (RA[i]) rd(RA[i], 32'h0);
    rd(8'h70, 32'h0, aei_pkg::RESP_SLVERR);
    wr(8'h50, 32'h33);
    wr(8'h5c, 32'hff);
    rd(8'h58, 32'h0f);
    seed_data <= 16'(rnd()) | 16'h8000;
    evp(4'h1);
    rd(8'h60, 32'h5);
    `CHK(irq, 1'h1)
    seed_data <= 16'(rnd()) & 16'h7fff;
    evp(4'h1);
    rd(8'h60, 32'h7, OK, 2);
    rd(8'h68, {16'h0, seed_data});
    rd(8'h60, 32'h2);
    wr(8'h60, 32'h0, OK, 3);
    rd(8'h60, 32'h2);
    wr(8'h60, 32'h2);
    rd(8'h60, 32'h0);
    `CHK(irq, 1'h0)
    evp(4'h2);
    `CHK({n_start, n_flush, n_res, n_win}, {32'd3, 32'd1, 32'd3, 32'd1})
    // single enable lit: result and window outputs stay quiet
    wr(8'h50, 32'h01);
    seed_data <= 16'hffff;
    evp(4'h1);
    wr(8'h50, 32'h00);
    evp(4'h3);
    `CHK({n_start, n_flush, n_res, n_win}, {32'd4, 32'd1, 32'd3, 32'd1})
    wr(8'hc0, 32'hf);
    rd(8'h60, 32'h0);
    evp(4'h4);
    rd(8'h64, 32'h80);
    evp(4'h8);
    rd(8'h64, 32'h0);
    rd(8'h60, 32'h8);
    `CHK(irq, 1'h1)
    wr(8'h58, 32'h8);
    `CHK(irq, 1'h0)
    rd(8'h5c, 32'h7);
    wr(8'h60, 32'h8);
    sync_quiet <= 1'h1;
    evp(4'h4);
    sync_quiet <= 1'h0;
    evp(4'h8);
    rd(8'h60, 32'h0);
    // byte lane 0 off: the write is answered but changes nothing
    s_axi_wstrb <= 4'he;
    wr(8'h5c, 32'hf);
    s_axi_wstrb <= 4'hf;
    rd(8'h5c, 32'h7);
    wr(8'h70, 32'h0, aei_pkg::RESP_SLVERR);
    write_protect <= 1'h1;
    wr(8'h5c, 32'hf, aei_pkg::RESP_SLVERR);
    wr(8'h58, 32'hf, aei_pkg::RESP_SLVERR);
    write_protect <= 1'h0;
    rd(8'h5c, 32'h7);
    end_of_test;
  end
endmodule
`default_nettype wire
